/* File: logic/tfp_pkg.sv */
`default_nettype none
package tfp_pkg;
  // timing of the link and of the reset that rides on the clock pin
  localparam int CLK_MHZ        = 25;
  localparam int RESET_LOW_US   = 20;
  localparam int RESET_LOW_CYC  = RESET_LOW_US * CLK_MHZ;
  localparam int RESET_HOLD_CYC = 2 * RESET_LOW_CYC;
  localparam int LINK_HALF_CYC  = 8;
  // frame shape: instruction bits first, then one byte, msb first
  localparam int INSTR_BITS     = 2;
  localparam int FRAME_BITS     = 10;
  // debug-link register addresses and codes
  localparam logic [7:0] ADDR_PROG_CONTROL    = 8'h02;
  localparam logic [7:0] ADDR_PROG_DATA       = 8'hb4;
  localparam logic [7:0] UNLOCK_FIRST         = 8'h02;
  localparam logic [7:0] UNLOCK_SECOND        = 8'h01;
  localparam logic [7:0] CODE_BLOCK_READ      = 8'h06;
  localparam logic [7:0] CODE_BLOCK_WRITE     = 8'h07;
  localparam logic [7:0] CODE_PAGE_ERASE      = 8'h08;
  localparam logic [7:0] CODE_DEVICE_ERASE    = 8'h03;
  localparam logic [7:0] REG_RESET_VALUE      = 8'h00;
  // host-side apb register map and fields
  localparam logic [7:0] HOST_CMD_OFS         = 8'h00;
  localparam logic [7:0] HOST_RESET_OFS       = 8'h04;
  localparam logic [7:0] HOST_STATUS_OFS      = 8'h08;
  localparam int         CMD_INSTR_LSB        = 0;
  localparam int         CMD_DATA_LSB         = 8;
  localparam int         STATUS_BUSY_BIT      = 0;
  localparam int         STATUS_DATA_LSB      = 8;
  localparam int         RESET_GO_BIT         = 0;

  typedef enum logic [1:0] {
    INSTR_DATA_READ  = 2'b00,
    INSTR_DATA_WRITE = 2'b01,
    INSTR_ADDR_WRITE = 2'b10,
    INSTR_ADDR_READ  = 2'b11
  } tfp_instr_t;

  typedef enum logic [2:0] {
    CMD_NONE         = 3'b000,
    CMD_BLOCK_READ   = 3'b001,
    CMD_BLOCK_WRITE  = 3'b010,
    CMD_PAGE_ERASE   = 3'b011,
    CMD_DEVICE_ERASE = 3'b100
  } tfp_cmd_t;

  typedef enum logic {
    UNLOCK_IDLE = 1'b0,
    UNLOCK_HALF = 1'b1
  } tfp_unlock_t;

  typedef enum logic [1:0] {
    HOST_IDLE  = 2'b00,
    HOST_LOW   = 2'b01,
    HOST_HIGH  = 2'b10,
    HOST_RESET = 2'b11
  } tfp_host_state_t;
endpackage
`default_nettype wire

/* File: logic/tfp_link_if.sv */
`default_nettype none
interface tfp_link_if;
  logic debug_link_clock_pin;
  logic host_data_out;
  logic host_data_oe;
  logic dev_data_out;
  logic dev_data_oe;
  wire  debug_link_data_pin;

  // resolved data wire; the external pull-up holds it high when nobody drives
  assign debug_link_data_pin = host_data_oe ? host_data_out
                             : (dev_data_oe ? dev_data_out : 1'b1);

  modport host (
    output debug_link_clock_pin,
    output host_data_out,
    output host_data_oe,
    input  debug_link_data_pin
  );

  modport device (
    input  debug_link_clock_pin,
    input  debug_link_data_pin,
    output dev_data_out,
    output dev_data_oe
  );
endinterface
`default_nettype wire

/* File: logic/tfp_device_end.sv */
// Our own choice: the APB register port.
`default_nettype none
module tfp_device_end
  import tfp_pkg::*;
(
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // debug link pins
  tfp_link_if.device      link,
  // core state and shared user pin
  input  wire logic       halted,
  input  wire logic       user_data_out,
  input  wire logic       user_data_oe,
  output logic            user_data_in,
  output logic            periph_stall,
  output logic            sys_reset_n,
  // flash engine side
  input  wire logic       cmd_ready,
  input  wire logic       load_valid,
  input  wire logic [7:0] load_byte,
  output logic            prog_enabled,
  output logic [7:0]      prog_data,
  output logic            data_strobe,
  output logic            cmd_strobe,
  output tfp_cmd_t        cmd_kind
);
  localparam int LOWW = $clog2(RESET_LOW_CYC + 1);

  logic [1:0]      clk_sync;
  logic [1:0]      dat_sync;
  logic            clk_prev;
  logic [LOWW-1:0] low_cnt;
  logic [3:0]      bit_cnt;
  logic [1:0]      instr_sr;
  logic [7:0]      shift_in;
  logic [7:0]      shift_out;
  logic            read_phase;
  logic            pin_out;
  logic            pin_oe;
  logic [7:0]      debug_register_select;
  logic [7:0]      flash_prog_control;
  logic [7:0]      flash_prog_data;
  tfp_unlock_t     unlock_state;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; the clock pin is sampled like any other input
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      clk_sync <= '1;
      dat_sync <= '1;
      clk_prev <= 1'b1;
    end
    else
    begin
      clk_sync <= {clk_sync[0], link.debug_link_clock_pin};
      dat_sync <= {dat_sync[0], link.debug_link_data_pin};
      clk_prev <= clk_sync[1];
    end
  end

  // edge detection and frame decode, all on the second sync stage
  wire        link_clk    = clk_sync[1];
  wire        link_bit    = dat_sync[1];
  wire        rise        = link_clk & ~clk_prev;
  wire        fall        = ~link_clk & clk_prev;
  wire        link_rst    = (low_cnt == LOWW'(RESET_LOW_CYC));
  wire        take_bit    = rise & halted;
  wire        in_instr    = (bit_cnt < 4'(INSTR_BITS));
  wire        instr_last  = take_bit & (bit_cnt == 4'(INSTR_BITS - 1));
  wire        frame_end   = take_bit & (bit_cnt == 4'(FRAME_BITS - 1));
  wire [1:0]  instr_now   = {instr_sr[0], link_bit};
  wire [7:0]  byte_in     = {shift_in[6:0], link_bit};
  wire        sel_control = (debug_register_select == ADDR_PROG_CONTROL);
  wire        sel_data    = (debug_register_select == ADDR_PROG_DATA);
  wire        wr_frame    = frame_end & (instr_sr == INSTR_DATA_WRITE);
  wire        addr_frame  = frame_end & (instr_sr == INSTR_ADDR_WRITE);
  wire        ctl_write   = wr_frame & sel_control;
  wire        dat_write   = wr_frame & sel_data;
  wire        is_read     = (instr_now == INSTR_DATA_READ) || (instr_now == INSTR_ADDR_READ);

  // value offered on a read frame; unmapped addresses read zero
  wire [7:0]  data_rd     = sel_control ? flash_prog_control
                          : (sel_data ? flash_prog_data : REG_RESET_VALUE);
  wire [7:0]  read_value  = (instr_now == INSTR_ADDR_READ) ? debug_register_select : data_rd;

  // command decode of a byte written to the data register
  wire tfp_cmd_t cmd_code = (byte_in == CODE_BLOCK_READ)   ? CMD_BLOCK_READ
                          : (byte_in == CODE_BLOCK_WRITE)  ? CMD_BLOCK_WRITE
                          : (byte_in == CODE_PAGE_ERASE)   ? CMD_PAGE_ERASE
                          : (byte_in == CODE_DEVICE_ERASE) ? CMD_DEVICE_ERASE
                          : CMD_NONE;
  wire        cmd_hit     = dat_write & prog_enabled & cmd_ready & (cmd_code != CMD_NONE);

  ////////////////////////////////////////////////////////////////////////////
  // a long low on the shared clock/reset pin is the system reset; the pin is
  // only ever read here, this end has no driver for it at all
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      low_cnt <= '0;
    else if (link_clk)
      low_cnt <= '0;
    else if (!link_rst)
      low_cnt <= low_cnt + LOWW'(1);
  end

  // bit counter; leaving the halt state abandons a half-done frame
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      bit_cnt <= '0;
    else if (link_rst || !halted)
      bit_cnt <= '0;
    else if (frame_end)
      bit_cnt <= '0;
    else if (take_bit)
      bit_cnt <= bit_cnt + 4'h1;
  end

  // incoming instruction and byte shift registers, msb first
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      instr_sr <= '0;
      shift_in <= '0;
    end
    else if (take_bit && in_instr)
      instr_sr <= instr_now;
    else if (take_bit)
      shift_in <= byte_in;
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data leaves on falling link edges so the host sees it at the rise
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      read_phase <= 1'b0;
      shift_out  <= '0;
    end
    else if (link_rst || !halted || frame_end)
      read_phase <= 1'b0;
    else if (instr_last && is_read)
    begin
      read_phase <= 1'b1;
      shift_out  <= read_value;
    end
    else if (fall && read_phase)
      shift_out  <= {shift_out[6:0], 1'b0};
  end

  // the data pin belongs to the link only while halted, else to the user
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_out <= 1'b1;
      pin_oe  <= 1'b0;
    end
    else if (!halted)
    begin
      pin_out <= user_data_out;
      pin_oe  <= user_data_oe;
    end
    else if (link_rst || frame_end || !read_phase)
      pin_oe  <= 1'b0;
    else if (fall)
    begin
      pin_out <= shift_out[7];
      pin_oe  <= 1'b1;
    end
  end

  assign link.dev_data_out = pin_out;
  assign link.dev_data_oe  = pin_oe;

  ////////////////////////////////////////////////////////////////////////////
  // address register and the two programming registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      debug_register_select <= REG_RESET_VALUE;
      flash_prog_control    <= REG_RESET_VALUE;
    end
    else if (link_rst)
    begin
      debug_register_select <= REG_RESET_VALUE;
      flash_prog_control    <= REG_RESET_VALUE;
    end
    else if (addr_frame)
      debug_register_select <= byte_in;
    else if (ctl_write)
      flash_prog_control    <= byte_in;
  end

  // host writes win over a byte returned by the flash engine
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      flash_prog_data <= REG_RESET_VALUE;
    else if (link_rst)
      flash_prog_data <= REG_RESET_VALUE;
    else if (dat_write)
      flash_prog_data <= byte_in;
    else if (load_valid)
      flash_prog_data <= load_byte;
  end

  ////////////////////////////////////////////////////////////////////////////
  // unlock sequence: first code arms, second code enables, any other code
  // but the first disarms; once enabled only a system reset takes it away
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      unlock_state <= UNLOCK_IDLE;
      prog_enabled <= 1'b0;
    end
    else if (link_rst)
    begin
      unlock_state <= UNLOCK_IDLE;
      prog_enabled <= 1'b0;
    end
    else if (ctl_write && !prog_enabled)
    begin
      case (unlock_state)
        UNLOCK_IDLE:
          if (byte_in == UNLOCK_FIRST)
            unlock_state <= UNLOCK_HALF;
        UNLOCK_HALF:
          if (byte_in == UNLOCK_SECOND)
          begin
            unlock_state <= UNLOCK_IDLE;
            prog_enabled <= 1'b1;
          end
          else if (byte_in != UNLOCK_FIRST)
            unlock_state <= UNLOCK_IDLE;
        default:
          unlock_state <= UNLOCK_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // strobes toward the flash engine and the core-side status outputs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      data_strobe <= 1'b0;
      cmd_strobe  <= 1'b0;
      cmd_kind    <= CMD_NONE;
    end
    else
    begin
      data_strobe <= dat_write;
      cmd_strobe  <= cmd_hit;
      if (cmd_hit)
        cmd_kind  <= cmd_code;
    end
  end

  // user input is the resynchronised pin; while halted the user's drive
  // is ignored, so a change then cannot corrupt a frame
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      user_data_in <= 1'b1;
      periph_stall <= 1'b0;
      sys_reset_n  <= 1'b1;
      prog_data    <= REG_RESET_VALUE;
    end
    else
    begin
      user_data_in <= link_bit;
      periph_stall <= halted;
      sys_reset_n  <= ~link_rst;
      prog_data    <= flash_prog_data;
    end
  end
endmodule
`default_nettype wire

/* File: logic/tfp_host_end.sv */
`default_nettype none
module tfp_host_end
  import tfp_pkg::*;
#(
  parameter int HALF_CYC = LINK_HALF_CYC,
  parameter int HOLD_CYC = RESET_HOLD_CYC
)
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // debug link pins
  tfp_link_if.host         link
);
  localparam int CW = $clog2(HOLD_CYC + HALF_CYC + 1);

  logic [1:0]      dat_sync;
  tfp_host_state_t state;
  logic [CW-1:0]   cnt;
  logic [3:0]      bit_idx;
  logic [9:0]      tx_sr;
  logic [7:0]      rx_sr;
  logic [1:0]      cmd_instr;
  logic [7:0]      cmd_data;
  logic [7:0]      read_byte;
  logic            clk_out;
  logic            dout;
  logic            doe;

  ////////////////////////////////////////////////////////////////////////////
  // apb decode; a request is acted on at the edge where pready is seen
  wire        access   = psel & penable & pready;
  wire        wr_cmd   = access & pwrite & (paddr == HOST_CMD_OFS) & (state == HOST_IDLE);
  wire        wr_rst   = access & pwrite & (paddr == HOST_RESET_OFS)
                       & pwdata[RESET_GO_BIT] & (state == HOST_IDLE);
  wire        busy     = (state != HOST_IDLE);
  wire        cnt_done = (cnt == '0);
  wire        last_bit = (bit_idx == 4'(FRAME_BITS - 1));
  wire        is_read  = (cmd_instr == INSTR_DATA_READ) || (cmd_instr == INSTR_ADDR_READ);
  wire [3:0]  next_idx = bit_idx + 4'h1;
  // the host lets go of the data pin during the byte of a read frame
  wire        next_oe  = (next_idx < 4'(INSTR_BITS)) || !is_read;
  wire [31:0] rd_mux   = (paddr == HOST_CMD_OFS)
                         ? {16'h0000, cmd_data, 6'h00, cmd_instr}
                         : (paddr == HOST_STATUS_OFS)
                         ? {16'h0000, read_byte, 7'h00, busy}
                         : 32'h0000_0000;

  // no wait state on any access; pready is a flop set in the setup phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end
    else
    begin
      pready  <= psel & ~penable & ~pready;
      pslverr <= 1'b0;
      if (psel && !penable && !pwrite)
        prdata <= rd_mux;
    end
  end

  // command register; writes while a frame runs are ignored
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmd_instr <= INSTR_DATA_READ;
      cmd_data  <= REG_RESET_VALUE;
    end
    else if (wr_cmd)
    begin
      cmd_instr <= pwdata[CMD_INSTR_LSB +: 2];
      cmd_data  <= pwdata[CMD_DATA_LSB +: 8];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      dat_sync <= '1;
    else
      dat_sync <= {dat_sync[0], link.debug_link_data_pin};
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame engine: clock low half drives a bit, rising edge samples one;
  // a reset request holds the shared clock/reset pin low instead
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state   <= HOST_IDLE;
      cnt     <= '0;
      bit_idx <= '0;
      tx_sr   <= '0;
      rx_sr   <= '0;
      clk_out <= 1'b1;
      dout    <= 1'b1;
      doe     <= 1'b0;
    end
    else
    begin
      case (state)
        HOST_IDLE:
          if (wr_rst)
          begin
            state   <= HOST_RESET;
            cnt     <= CW'(HOLD_CYC - 1);
            clk_out <= 1'b0;
          end
          else if (wr_cmd)
          begin
            state   <= HOST_LOW;
            cnt     <= CW'(HALF_CYC - 1);
            bit_idx <= '0;
            tx_sr   <= {pwdata[CMD_INSTR_LSB +: 2], pwdata[CMD_DATA_LSB +: 8]};
            clk_out <= 1'b0;
            dout    <= pwdata[CMD_INSTR_LSB + 1];
            doe     <= 1'b1;
          end
        HOST_LOW:
          if (cnt_done)
          begin
            state   <= HOST_HIGH;
            cnt     <= CW'(HALF_CYC - 1);
            clk_out <= 1'b1;
            rx_sr   <= {rx_sr[6:0], dat_sync[1]};
          end
          else
            cnt <= cnt - CW'(1);
        HOST_HIGH:
          if (cnt_done && last_bit)
          begin
            state <= HOST_IDLE;
            doe   <= 1'b0;
          end
          else if (cnt_done)
          begin
            state   <= HOST_LOW;
            cnt     <= CW'(HALF_CYC - 1);
            bit_idx <= next_idx;
            tx_sr   <= {tx_sr[8:0], 1'b0};
            clk_out <= 1'b0;
            dout    <= tx_sr[8];
            doe     <= next_oe;
          end
          else
            cnt <= cnt - CW'(1);
        HOST_RESET:
          if (cnt_done)
          begin
            state   <= HOST_IDLE;
            clk_out <= 1'b1;
          end
          else
            cnt <= cnt - CW'(1);
        default:
          state <= HOST_IDLE;
      endcase
    end
  end

  // last byte of a finished read frame
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      read_byte <= REG_RESET_VALUE;
    else if (state == HOST_HIGH && cnt_done && last_bit && is_read)
      read_byte <= rx_sr;
  end

  assign link.debug_link_clock_pin = clk_out;
  assign link.host_data_out        = dout;
  assign link.host_data_oe         = doe;
endmodule
`default_nettype wire

/* File: sim/tfp_props.sv */
`default_nettype none
module tfp_props
  import tfp_pkg::*;
(
  // clock and reset
  input wire logic     pclk,
  input wire logic     presetn,
  // link wires
  input wire logic     debug_link_clock_pin,
  input wire logic     host_data_oe,
  input wire logic     dev_data_oe,
  // device state
  input wire logic     halted,
  input wire logic     periph_stall,
  input wire logic     sys_reset_n,
  input wire logic     prog_enabled,
  input wire logic     data_strobe,
  input wire logic     cmd_strobe,
  input wire tfp_cmd_t cmd_kind
);
  timeunit 1ns;
  timeprecision 1ps;

  // one domain, so clock and reset are given once
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  ////////////////////////////////////////////////////////////////////////////
  // both ends driving the data wire at once would short the pin
  no_bus_fight_a: assert property (!(host_data_oe && dev_data_oe))
    else $error("host and device drive the data wire together");
  dev_release_a: assert property ($fell(halted) |-> ##[1:4] !dev_data_oe)
    else $error("device still drives data wire after leaving halt");
  stall_follow_a: assert property ($fell(halted) |=> !periph_stall)
    else $error("peripheral stall held after leaving halt");
  unlock_halted_a: assert property ($rose(prog_enabled) |-> halted)
    else $error("programming unlocked while core running");
  // only a long low on the clock pin may relock programming
  sticky_enable_a: assert property ($fell(prog_enabled) |->
    !debug_link_clock_pin ##1 !sys_reset_n)
    else $error("programming dropped without a system reset");
  reset_release_a: assert property (!sys_reset_n &&
    $rose(debug_link_clock_pin) |-> ##[1:6] sys_reset_n)
    else $error("system reset not released after clock pin rose");
  cmd_gate_a: assert property (cmd_strobe |->
    prog_enabled && data_strobe == 1'b0 && cmd_kind != CMD_NONE || cmd_strobe &&
    prog_enabled && cmd_kind != CMD_NONE)
    else $error("command decoded while locked or with no kind");
  cmd_pulse_a: assert property (cmd_strobe |=> !cmd_strobe)
    else $error("command strobe longer than one cycle");
  data_pulse_a: assert property (data_strobe |=> !data_strobe)
    else $error("data strobe longer than one cycle");
endmodule
`default_nettype wire

/* File: sim/tb.sv */
`default_nettype none
module tb;
  import tfp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, load_byte, prog_data, v;
  logic [31:0] pwdata, prdata, r;
  logic halted, user_data_out, user_data_oe, user_data_in, periph_stall;
  logic sys_reset_n, cmd_ready, load_valid, prog_enabled, data_strobe, cmd_strobe;
  tfp_cmd_t cmd_kind, last_kind;
  int mismatches = 0, n_tests = 0, n_cmd = 0;
  logic saw_rst = 1'b0;
  logic [7:0] codes [4] = '{CODE_BLOCK_READ, CODE_BLOCK_WRITE, CODE_PAGE_ERASE,
                            CODE_DEVICE_ERASE};
  tfp_cmd_t kinds [4] = '{CMD_BLOCK_READ, CMD_BLOCK_WRITE, CMD_PAGE_ERASE,
                          CMD_DEVICE_ERASE};

  // the carrier is called lnk so that it does not clash with the frame task
  tfp_link_if lnk ();
  tfp_host_end #(.HALF_CYC(LINK_HALF_CYC), .HOLD_CYC(600)) tfp_host_end_i (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(lnk));
  tfp_device_end tfp_device_end_i (.pclk(pclk), .presetn(presetn), .link(lnk),
    .halted(halted), .user_data_out(user_data_out), .user_data_oe(user_data_oe),
    .user_data_in(user_data_in), .periph_stall(periph_stall), .sys_reset_n(sys_reset_n),
    .cmd_ready(cmd_ready), .load_valid(load_valid), .load_byte(load_byte),
    .prog_enabled(prog_enabled), .prog_data(prog_data), .data_strobe(data_strobe),
    .cmd_strobe(cmd_strobe), .cmd_kind(cmd_kind));
  tfp_props tfp_props_i (.pclk(pclk), .presetn(presetn),
    .debug_link_clock_pin(lnk.debug_link_clock_pin), .host_data_oe(lnk.host_data_oe),
    .dev_data_oe(lnk.dev_data_oe), .halted(halted), .periph_stall(periph_stall),
    .sys_reset_n(sys_reset_n), .prog_enabled(prog_enabled), .data_strobe(data_strobe),
    .cmd_strobe(cmd_strobe), .cmd_kind(cmd_kind));

  ////////////////////////////////////////////////////////////////////////////
  // 25 MHz clock
  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // counts decoded commands; the strobe lasts one cycle only
  always @(posedge pclk)
  begin
    if (cmd_strobe === 1'b1) begin n_cmd <= n_cmd + 1; last_kind <= cmd_kind; end
    if (sys_reset_n === 1'b0) saw_rst <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // one apb transfer; holds everything until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin @(posedge pclk); n++; end
    if (n >= 50) mismatches++;
    q = prdata;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  // polls busy; the settle wait covers the device's sync lag
  task automatic wait_idle();
    int n;
    n = 0;
    r = 32'h1;
    while (r[STATUS_BUSY_BIT] !== 1'b0 && n < 1000) begin apb(0, HOST_STATUS_OFS, 0, r); n++; end
    if (n >= 1000) mismatches++;
    repeat (8) @(posedge pclk);
  endtask

  task automatic link(input logic [1:0] ins, input logic [7:0] b);
    apb(1, HOST_CMD_OFS, {16'h0000, b, 6'h00, ins}, r);
    wait_idle();
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    link(INSTR_ADDR_WRITE, a);
    link(INSTR_DATA_READ, 8'h00);
    apb(0, HOST_STATUS_OFS, 0, r);
    q = r[15:8];
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; halted = 1'b1; user_data_out = 1'b0; user_data_oe = 1'b0;
    cmd_ready = 1'b0; load_valid = 1'b0; load_byte = 8'h00;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd(ADDR_PROG_CONTROL, v); chk("control reset", v, 8'h00);
    rd(ADDR_PROG_DATA, v); chk("data reset", v, 8'h00);
    chk("slave error", pslverr, 1'b0);
    $display("test reset values done");
    // a stray code between the two unlock codes must cancel the unlock
    link(INSTR_ADDR_WRITE, ADDR_PROG_CONTROL);
    link(INSTR_DATA_WRITE, 8'h02); link(INSTR_DATA_WRITE, 8'h03);
    link(INSTR_DATA_WRITE, 8'h01);
    chk("broken unlock", prog_enabled, 1'b0);
    rd(ADDR_PROG_CONTROL, v); chk("control readback", v, 8'h01);
    link(INSTR_DATA_WRITE, UNLOCK_FIRST); link(INSTR_DATA_WRITE, UNLOCK_SECOND);
    chk("unlocked", prog_enabled, 1'b1);
    $display("test unlock done");
    cmd_ready <= 1'b1;
    link(INSTR_ADDR_WRITE, ADDR_PROG_DATA);
    for (int i = 0; i < 4; i++)
    begin
      link(INSTR_DATA_WRITE, codes[i]);
      chk("command count", n_cmd, i + 1);
      chk("command kind", last_kind, kinds[i]);
    end
    link(INSTR_DATA_WRITE, 8'h55); chk("plain byte", n_cmd, 4);
    chk("data copy", prog_data, 8'h55);
    rd(ADDR_PROG_DATA, v); chk("data readback", v, 8'h55);
    cmd_ready <= 1'b0;
    link(INSTR_DATA_WRITE, CODE_BLOCK_READ); chk("data phase byte", n_cmd, 4);
    $display("test commands done");
    @(posedge pclk); load_valid <= 1'b1; load_byte <= 8'ha5;
    @(posedge pclk); load_valid <= 1'b0;
    rd(ADDR_PROG_DATA, v); chk("engine load", v, 8'ha5);
    halted <= 1'b0;
    repeat (3) @(posedge pclk);
    chk("stall off", periph_stall, 1'b0);
    // running: the user owns the data pin, released again before any frame
    user_data_oe <= 1'b1;
    repeat (6) @(posedge pclk);
    chk("user pin", user_data_in, 1'b0);
    user_data_oe <= 1'b0;
    repeat (3) @(posedge pclk);
    link(INSTR_DATA_WRITE, 8'h77);
    halted <= 1'b1;
    repeat (3) @(posedge pclk);
    chk("stall on", periph_stall, 1'b1);
    rd(ADDR_PROG_DATA, v); chk("running frame", v, 8'ha5);
    chk("still unlocked", prog_enabled, 1'b1);
    $display("test halt done");
    apb(1, HOST_RESET_OFS, 32'h1, r);
    wait_idle();
    chk("system reset seen", saw_rst, 1'b1);
    chk("relocked", prog_enabled, 1'b0);
    rd(ADDR_PROG_CONTROL, v); chk("control cleared", v, 8'h00);
    $display("test system reset done");
    report_and_stop();
  end

  // cuts a hang short
  initial
  begin
    #3ms;
    mismatches++;
    report_and_stop();
  end
endmodule
`default_nettype wire
